// *** bench/rfid_cmd_port_asserts.sv ***
// port-level checker for rfid_cmd_port
// assumes single clock aclk, sync active-low aresetn, bound onto the rtl top
`timescale 1ns/1ps
`include "rfid_cmd_port_defs.vh"
module rfid_cmd_port_asserts (
  input wire       aclk,
  input wire       aresetn,
  input wire       fb_srv_valid,
  input wire [3:0] fb_srv_code,
  input wire       fb_srv_ack,
  input wire       fb_srv_rej,
  input wire       diag_event,
  input wire       fb_diag_irq,
  input wire       dx_enable,
  input wire       bus_err_led,
  input wire [6:0] in_bytes,
  input wire [6:0] out_bytes,
  input wire [6:0] station_addr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  irq_has_cause_a: assert property (fb_diag_irq |-> $past(diag_event)) else $error("irq without event");
  led_vs_dx_a: assert property (dx_enable != bus_err_led) else $error("led and dx agree");
  addr_range_a: assert property (station_addr <= `ADDR_MAX) else $error("address out of range");
  out_size_a: assert property (out_bytes == `IN_RO_OUT || out_bytes == in_bytes) else $error("bad out size");
  in_size_a: assert property ((in_bytes[1:0] == 2'd0 && in_bytes >= 7'd8 && in_bytes <= 7'd32)
    || in_bytes == 7'd64) else $error("bad in size");
  srv_cause_a: assert property (fb_srv_ack || fb_srv_rej |-> $past(fb_srv_valid)) else $error("stray answer");
  srv_answer_a: assert property (fb_srv_valid |=> fb_srv_ack != fb_srv_rej) else $error("no single answer");
  // led stable over two cycles so either register view of the hold bit agrees
  dx_blocked_a: assert property (fb_srv_valid && fb_srv_code == `SRV_DX && bus_err_led ##1 bus_err_led
    |-> fb_srv_rej) else $error("data exchange not refused");
  cover property (fb_diag_irq);
  cover property (fb_srv_rej);
  cover property (bus_err_led ##1 dx_enable);
endmodule // rfid_cmd_port_asserts
bind rfid_cmd_port rfid_cmd_port_asserts chk (.aclk(aclk), .aresetn(aresetn), .fb_srv_valid(fb_srv_valid),
  .fb_srv_code(fb_srv_code), .fb_srv_ack(fb_srv_ack), .fb_srv_rej(fb_srv_rej), .diag_event(diag_event),
  .fb_diag_irq(fb_diag_irq), .dx_enable(dx_enable), .bus_err_led(bus_err_led), .in_bytes(in_bytes),
  .out_bytes(out_bytes), .station_addr(station_addr));

// *** bench/rfid_unit_host_command_port_tb_top.sv ***
// self-checking bench for rfid_cmd_port: axi tasks, terminal partner, model
// assumes term_model and bound checker; short BAUD_DIV and TICK_STEP
`timescale 1ns/1ps
`include "rfid_cmd_port_defs.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module rfid_unit_host_command_port_tb_top;
  localparam integer BD = 16;
  logic        aclk, aresetn, awvalid, wvalid, arvalid, awready, wready, arready, bvalid, rvalid;
  logic        head, srv_v, ack, rej, code_v, diag, irq, dx, led, urx, utx, fbl;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, ncode, in_code, a, b;
  logic [1:0]  bresp, rresp;
  logic [3:0]  srv_c;
  logic [6:0]  in_b, out_b, st_addr;
  int          n_mismatch, num_checks, n, ein;
  byte         tag_m;
  rfid_cmd_port #(.BAUD_DIV(BD), .TICK_STEP(20)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .uart_rx(urx), .uart_tx(utx), .head_present(head), .fb_line(fbl),
    .fb_srv_valid(srv_v), .fb_srv_code(srv_c), .fb_srv_ack(ack), .fb_srv_rej(rej),
    .new_code_valid(code_v), .new_code(ncode), .in_code(in_code), .diag_event(diag),
    .fb_diag_irq(irq), .dx_enable(dx), .bus_err_led(led), .in_bytes(in_b), .out_bytes(out_b),
    .station_addr(st_addr));
  term_model #(.BAUD_DIV(BD)) term (.aclk(aclk), .uart_rx(urx), .uart_tx(utx));
  ////////////////////////////////////////
  task automatic wr(input [7:0] ad, input [31:0] d, input [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input [7:0] ad, input [31:0] ed, input [1:0] er);
    araddr <= ad;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask
  task automatic srv(input [3:0] c, input logic ea);
    srv_c <= c;
    srv_v <= 1;
    @(posedge aclk);
    srv_v <= 0;
    @(posedge aclk);
    `CHK("ack", ea, ack)
    `CHK("rej", !ea, rej)
  endtask
  task automatic cmd(input string s, input string e);
    term.q.delete();
    term.send(s);
    n = 0;
    while (term.q.size() < e.len() && n < 40000) begin
      @(posedge aclk);
      n++;
    end
    // extra wait so a surplus or unwanted reply shows up
    repeat (30 * BD) @(posedge aclk);
    `CHK("reply_len", e.len(), term.q.size())
    for (int i = 0; i < e.len() && i < term.q.size(); i++) `CHK("reply", e[i], term.q[i])
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    repeat (95000) @(posedge aclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, srv_v, code_v, diag, awaddr, araddr, wdata, srv_c, ncode} = 0;
    head = 1;
    fbl = 1;
    tag_m = 8'h99;
    void'($urandom(32'h71ad1abd));
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rd(`OFS_SIZE, 32'h0000_0808, `RESP_OKAY);
    rd(`OFS_ADDR, 32'h0000_007E, `RESP_OKAY);
    rd(`OFS_HOLD, 32'h0000_0000, `RESP_OKAY);
    rd(`OFS_STATUS, 32'h0000_9903, `RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, `RESP_SLVERR);
    wr(`OFS_STATUS, 32'h0000_0000, `RESP_SLVERR);
    wr(`OFS_ADDR, 32'h0000_007F, `RESP_OKAY);
    rd(`OFS_ADDR, 32'h0000_007E, `RESP_OKAY);
    a = $urandom % 127;
    wr(`OFS_ADDR, a, `RESP_OKAY);
    rd(`OFS_ADDR, a, `RESP_OKAY);
    `CHK("station_addr", a[6:0], st_addr)
    // line level held 6 cycles; run counter restarts at zero on each edge
    for (int t = 0; t < 8; t++) begin
      fbl <= t[0];
      repeat (6) @(posedge aclk);
    end
    rd(`OFS_RATE, 32'h0000_0005, `RESP_OKAY);
    $display("test regs done");
    for (int m = 0; m < 16; m++) begin
      ein = (m % 8 == 7) ? 64 : 8 + 4 * (m % 8);
      wr(`OFS_CTRL, (m % 8) * 4 + (m / 8) * 2, `RESP_OKAY);
      rd(`OFS_SIZE, ((m / 8) ? 4 : ein) * 256 + ein, `RESP_OKAY);
      `CHK("in_bytes", ein[6:0], in_b)
    end
    $display("test sizes done");
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 4 : (i == 1) ? 32'h5D : 0;
      wr(`OFS_HOLD, b, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      `CHK("led", b[2], led)
      srv(`SRV_DX, !b[2]);
    end
    for (int c = 0; c <= 8; c++) srv(c, 1'b1);
    srv(4'd9 + $urandom % 7, 1'b0);
    $display("test fieldbus done");
    for (int e = 1; e >= 0; e--) begin
      wr(`OFS_CTRL, e, `RESP_OKAY);
      diag <= 1;
      @(posedge aclk);
      diag <= 0;
      @(posedge aclk);
      `CHK("irq", e[0], irq)
    end
    $display("test irq done");
    wr(`OFS_HOLD, 1, `RESP_OKAY);
    a = $urandom;
    b = $urandom;
    for (int k = 0; k < 3; k++) begin
      ncode <= (k == 0) ? a : (k == 1) ? ~b : b;
      code_v <= 1;
      @(posedge aclk);
      code_v <= 0;
      repeat (3) @(posedge aclk);
    end
    `CHK("in_code", a, in_code)
    repeat (18) @(posedge aclk);
    `CHK("in_code", b, in_code)
    $display("test hold done");
    cmd("VE#\015", {`STR_VE1, `STR_VE2});
    head <= 0;
    cmd("VE#\015", {`STR_VE1, `STR_NOHD});
    cmd("CT133#\015", "00041000#\015");
    tag_m = 8'h33;
    cmd($sformatf("GS%c%c", 8'(8'h47 + 8'h53), `CH_ETX), {`STR_GS, $sformatf("1%02X#\015", tag_m)});
    cmd($sformatf("GS%c%c", 8'h9B, `CH_ETX), "");
    cmd("CT245#\015", "00042000#\015");
    cmd("GS#\015", {`STR_GS, $sformatf("1%02X#\015", tag_m)});
    $display("test serial done");
    print_verdict;
  end
endmodule // rfid_unit_host_command_port_tb_top

// *** bench/term_model.sv ***
// serial terminal model: sends command text, collects reply bytes
// assumes 8N1 at BAUD_DIV clocks per bit on the shared clock
`timescale 1ns/1ps
module term_model #(
  parameter integer BAUD_DIV = 16
) (
  input  wire  aclk,
  output logic uart_rx,
  input  wire  uart_tx
);
  byte q[$];
  byte c;
  initial uart_rx = 1'b1;
  task automatic send(input string s);
    logic [9:0] frm;
    for (int i = 0; i < s.len(); i++) begin
      frm = {1'b1, s[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        @(posedge aclk);
        uart_rx <= frm[b];
        repeat (BAUD_DIV - 1) @(posedge aclk);
      end
    end
  endtask
  // sample mid-bit; stop bit skipped so back-to-back replies are caught
  always begin
    @(posedge aclk);
    if (uart_tx === 1'b0) begin
      repeat (BAUD_DIV / 2) @(posedge aclk);
      for (int b = 0; b < 8; b++) begin
        repeat (BAUD_DIV) @(posedge aclk);
        c[b] = uart_tx;
      end
      repeat (BAUD_DIV) @(posedge aclk);
      q.push_back(c);
    end
  end
endmodule // term_model

// *** include/rfid_cmd_port_defs.vh ***
// constants for the rfid diagnostic command port and fieldbus-side parameters
// assumes a single 200 MHz clock; included by bare name from the rtl file
`ifndef RFID_CMD_PORT_DEFS_VH
`define RFID_CMD_PORT_DEFS_VH

`define CLK_HZ        200000000
`define UART_BAUD     38400
`define HOLD_STEP_MS  10
`define MS_PER_S      1000

// register byte offsets
`define OFS_CTRL      8'h00
`define OFS_HOLD      8'h04
`define OFS_ADDR      8'h08
`define OFS_STATUS    8'h0C
`define OFS_CODE      8'h10
`define OFS_RATE      8'h14
`define OFS_SIZE      8'h18

`define ADDR_RST      7'h7E
`define ADDR_MAX      7'h7E
`define TAG_RST       8'h99
`define HOLD_BLOCK_BIT 2
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// characters
`define CH_HASH       8'h23
`define CH_CR         8'h0D
`define CH_ETX        8'h03
`define CH_ZERO       8'h30

// response kinds
`define K_NONE        3'd0
`define K_VE1         3'd1
`define K_VE2         3'd2
`define K_NOHD        3'd3
`define K_GS          3'd4
`define K_CT          3'd5

// fixed response texts; part and software numbers are arbitrary
`define STR_VE1  "00030028(C) ID\015\012UNIT\015\012#000000\015\0120000000\015\01201.01.01#\015"
`define LEN_VE1  50
`define STR_VE2  "00031020HEAD\015\012#000000\015\0120000000\015\01201.01.01#\015"
`define LEN_VE2  42
`define STR_NOHD "60031000#\015"
`define LEN_NOHD 10
`define STR_GS   "00950016 TO:0 BD:38400 HD1:"
`define LEN_GSP  27
`define LEN_GS   32
`define STR_CT   "00041000#\015"
`define LEN_CT   10
`define CT_CHAN_IDX 4

// fieldbus service codes and read-only output size
`define SRV_DX        4'h0
`define SRV_LAST      4'h8
`define IN_RO_OUT     7'd4
`endif

// *** rtl/rfid_cmd_port.v ***
// rfid unit host command port: serial diagnostic interpreter plus fieldbus-side
// parameter block. assumes one clock aclk, AXI4-Lite master on the register bus,
// and an external fieldbus engine that reports services and head events.
`timescale 1ns/1ps
`include "rfid_cmd_port_defs.vh"

module rfid_cmd_port #(
  parameter integer BAUD_DIV  = `CLK_HZ / `UART_BAUD,
  parameter integer TICK_STEP = `CLK_HZ / `MS_PER_S * `HOLD_STEP_MS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        uart_rx,
  output reg         uart_tx,
  input  wire        head_present,
  input  wire        fb_line,
  input  wire        fb_srv_valid,
  input  wire [3:0]  fb_srv_code,
  output reg         fb_srv_ack,
  output reg         fb_srv_rej,
  input  wire        new_code_valid,
  input  wire [31:0] new_code,
  output reg  [31:0] in_code,
  input  wire        diag_event,
  output reg         fb_diag_irq,
  output reg         dx_enable,
  output reg         bus_err_led,
  output reg  [6:0]  in_bytes,
  output reg  [6:0]  out_bytes,
  output reg  [6:0]  station_addr
);

  localparam [8*`LEN_VE1-1:0]  S_VE1  = `STR_VE1;
  localparam [8*`LEN_VE2-1:0]  S_VE2  = `STR_VE2;
  localparam [8*`LEN_NOHD-1:0] S_NOHD = `STR_NOHD;
  localparam [8*`LEN_GSP-1:0]  S_GS   = `STR_GS;
  localparam [8*`LEN_CT-1:0]   S_CT   = `STR_CT;
  localparam [1:0] RX_IDLE = 2'd0, RX_START = 2'd1, RX_DATA = 2'd2, RX_STOP = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [7:0] hexc;
    input [3:0] n;
    begin
      hexc = (n < 4'd10) ? (`CH_ZERO + {4'h0, n}) : (8'h37 + {4'h0, n});
    end
  endfunction

  function [3:0] hexv;
    input [7:0] c;
    begin
      if (c >= 8'h41)
        hexv = c[3:0] + 4'h9;
      else
        hexv = c[3:0];
    end
  endfunction

  function [5:0] resp_len;
    input [2:0] k;
    begin
      case (k)
        `K_VE1:  resp_len = `LEN_VE1;
        `K_VE2:  resp_len = `LEN_VE2;
        `K_NOHD: resp_len = `LEN_NOHD;
        `K_GS:   resp_len = `LEN_GS;
        `K_CT:   resp_len = `LEN_CT;
        default: resp_len = 6'd1;
      endcase
    end
  endfunction

  function [6:0] field_size;
    input [2:0] sel;
    begin
      field_size = (sel == 3'd7) ? 7'd64 : (7'd8 + {2'b00, sel, 2'b00});
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change taken once second and third stages agree

  reg [2:0] rx_sync_r, fb_sync_r;
  reg       rx_lvl_r, fb_lvl_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync_r <= 3'b111;
      fb_sync_r <= 3'b111;
      rx_lvl_r  <= 1'b1;
      fb_lvl_r  <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], uart_rx};
      fb_sync_r <= {fb_sync_r[1:0], fb_line};
      if (rx_sync_r[1] == rx_sync_r[2])
        rx_lvl_r <= rx_sync_r[2];
      if (fb_sync_r[1] == fb_sync_r[2])
        fb_lvl_r <= fb_sync_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial receiver, fixed 8N1, no configuration

  reg [1:0]  rx_st_r;
  reg [31:0] rx_cnt_r;
  reg [2:0]  rx_bit_r;
  reg [7:0]  rx_sh_r;
  reg        rx_vld_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_st_r  <= RX_IDLE;
      rx_cnt_r <= 32'h0000_0000;
      rx_bit_r <= 3'd0;
      rx_sh_r  <= 8'h00;
      rx_vld_r <= 1'b0;
    end else begin
      rx_vld_r <= 1'b0;
      rx_cnt_r <= rx_cnt_r + 32'h0000_0001;
      case (rx_st_r)
        RX_IDLE: begin
          rx_cnt_r <= 32'h0000_0000;
          if (!rx_lvl_r)
            rx_st_r <= RX_START;
        end
        RX_START: if (rx_cnt_r == BAUD_DIV / 2) begin
          rx_cnt_r <= 32'h0000_0000;
          rx_bit_r <= 3'd0;
          rx_st_r  <= rx_lvl_r ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_cnt_r == BAUD_DIV - 1) begin
          rx_cnt_r <= 32'h0000_0000;
          rx_sh_r  <= {rx_lvl_r, rx_sh_r[7:1]};
          rx_bit_r <= rx_bit_r + 3'd1;
          if (rx_bit_r == 3'd7)
            rx_st_r <= RX_STOP;
        end
        RX_STOP: if (rx_cnt_r == BAUD_DIV - 1) begin
          rx_vld_r <= rx_lvl_r;  // framing error drops the byte
          rx_st_r  <= RX_IDLE;
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command assembly and decode

  reg [7:0] cbuf_r [0:4];
  reg [2:0] ccnt_r;
  reg [7:0] sum_r, sum_prev_r, last_r;
  reg [2:0] tx_kind_r;
  reg [5:0] tx_idx_r;
  reg [7:0] tag_r, ct_chan_r;
  reg       tx_busy_r, tx_done_r;
  reg       term;
  reg [2:0] clen;
  integer   i;

  always @* begin
    term = 1'b0;
    clen = ccnt_r - 3'd1;
    if (ccnt_r != 3'd0) begin
      if (rx_sh_r == `CH_CR && last_r == `CH_HASH)
        term = 1'b1;
      if (rx_sh_r == `CH_ETX && last_r == sum_prev_r)
        term = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 5; i = i + 1)
        cbuf_r[i] <= 8'h00;
      ccnt_r     <= 3'd0;
      sum_r      <= 8'h00;
      sum_prev_r <= 8'h00;
      last_r     <= 8'h00;
      tx_kind_r  <= `K_NONE;
      tag_r      <= `TAG_RST;
      ct_chan_r  <= `CH_ZERO;
    end else begin
      if (tx_done_r) begin
        if (tx_kind_r == `K_VE1)
          tx_kind_r <= head_present ? `K_VE2 : `K_NOHD;
        else
          tx_kind_r <= `K_NONE;
      end
      if (rx_vld_r) begin
        if (rx_sh_r == `CH_CR || rx_sh_r == `CH_ETX) begin
          // any ending clears the buffer; a wrong sum just discards
          ccnt_r <= 3'd0;
          sum_r  <= 8'h00;
          last_r <= 8'h00;
          // commands arriving while a reply is going out are dropped
          if (term && tx_kind_r == `K_NONE) begin
            if (clen == 3'd2 && cbuf_r[0] == "V" && cbuf_r[1] == "E")
              tx_kind_r <= `K_VE1;
            if (clen == 3'd2 && cbuf_r[0] == "G" && cbuf_r[1] == "S")
              tx_kind_r <= `K_GS;
            if (clen == 3'd5 && cbuf_r[0] == "C" && cbuf_r[1] == "T") begin
              tx_kind_r <= `K_CT;
              ct_chan_r <= cbuf_r[2];
              if (cbuf_r[2] == "1")
                tag_r <= {hexv(cbuf_r[3]), hexv(cbuf_r[4])};
            end
          end
        end else begin
          if (ccnt_r < 3'd5)
            cbuf_r[ccnt_r] <= rx_sh_r;
          if (ccnt_r != 3'd7)
            ccnt_r <= ccnt_r + 3'd1;
          last_r     <= rx_sh_r;
          sum_prev_r <= sum_r;
          sum_r      <= sum_r + rx_sh_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reply serialiser; headers carry status, 0, code, channel, length

  reg [7:0] tx_char;

  always @* begin
    case (tx_kind_r)
      `K_VE1:  tx_char = S_VE1[(`LEN_VE1 - 1 - tx_idx_r) * 8 +: 8];
      `K_VE2:  tx_char = S_VE2[(`LEN_VE2 - 1 - tx_idx_r) * 8 +: 8];
      `K_NOHD: tx_char = S_NOHD[(`LEN_NOHD - 1 - tx_idx_r) * 8 +: 8];
      `K_GS: begin
        if (tx_idx_r < `LEN_GSP)
          tx_char = S_GS[(`LEN_GSP - 1 - tx_idx_r) * 8 +: 8];
        else if (tx_idx_r == `LEN_GSP)
          tx_char = head_present ? "0" : "1";
        else if (tx_idx_r == `LEN_GSP + 1)
          tx_char = hexc(tag_r[7:4]);
        else if (tx_idx_r == `LEN_GSP + 2)
          tx_char = hexc(tag_r[3:0]);
        else if (tx_idx_r == `LEN_GSP + 3)
          tx_char = `CH_HASH;
        else
          tx_char = `CH_CR;
      end
      `K_CT:   tx_char = (tx_idx_r == `CT_CHAN_IDX) ? ct_chan_r :
                         S_CT[(`LEN_CT - 1 - tx_idx_r) * 8 +: 8];
      default: tx_char = 8'h00;
    endcase
  end

  reg [9:0]  tx_sh_r;
  reg [3:0]  tx_bit_r;
  reg [31:0] tx_cnt_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      uart_tx   <= 1'b1;
      tx_busy_r <= 1'b0;
      tx_done_r <= 1'b0;
      tx_idx_r  <= 6'd0;
      tx_sh_r   <= 10'h3FF;
      tx_bit_r  <= 4'd0;
      tx_cnt_r  <= 32'h0000_0000;
    end else begin
      tx_done_r <= 1'b0;
      if (!tx_busy_r) begin
        uart_tx <= 1'b1;
        if (tx_kind_r != `K_NONE && !tx_done_r) begin
          tx_sh_r   <= {1'b1, tx_char, 1'b0};
          tx_busy_r <= 1'b1;
          tx_bit_r  <= 4'd0;
          tx_cnt_r  <= 32'h0000_0000;
        end
      end else begin
        uart_tx  <= tx_sh_r[0];
        tx_cnt_r <= tx_cnt_r + 32'h0000_0001;
        if (tx_cnt_r == BAUD_DIV - 1) begin
          tx_cnt_r <= 32'h0000_0000;
          tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
          tx_bit_r <= tx_bit_r + 4'd1;
          if (tx_bit_r == 4'd9) begin
            tx_busy_r <= 1'b0;
            if (tx_idx_r == resp_len(tx_kind_r) - 6'd1) begin
              tx_idx_r  <= 6'd0;
              tx_done_r <= 1'b1;
            end else
              tx_idx_r <= tx_idx_r + 6'd1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fieldbus side: services, bit-rate measure, hold time, diagnostics

  reg        irq_en_r, ro_mode_r;
  reg [2:0]  size_sel_r;
  reg [7:0]  hold_r, hold_left_r;
  reg [31:0] tick_cnt_r;
  reg        pend_r;
  reg [31:0] pend_code_r;
  reg [15:0] run_r, rate_min_r;
  reg        fb_prev_r;

  always @(posedge aclk) begin
    if (!aresetn) begin
      fb_srv_ack  <= 1'b0;
      fb_srv_rej  <= 1'b0;
      fb_diag_irq <= 1'b0;
      dx_enable   <= 1'b0;
      bus_err_led <= 1'b1;
      in_bytes    <= 7'd8;
      out_bytes   <= 7'd8;
      in_code     <= 32'h0000_0000;
      pend_r      <= 1'b0;
      pend_code_r <= 32'h0000_0000;
      hold_left_r <= 8'h00;
      tick_cnt_r  <= 32'h0000_0000;
      run_r       <= 16'h0000;
      rate_min_r  <= 16'hFFFF;
      fb_prev_r   <= 1'b1;
    end else begin
      dx_enable   <= ~hold_r[`HOLD_BLOCK_BIT];
      bus_err_led <= hold_r[`HOLD_BLOCK_BIT];
      // data exchange refused while parameters block it
      fb_srv_ack <= fb_srv_valid && fb_srv_code <= `SRV_LAST &&
                    (fb_srv_code != `SRV_DX || dx_enable);
      fb_srv_rej <= fb_srv_valid && !(fb_srv_code <= `SRV_LAST &&
                    (fb_srv_code != `SRV_DX || dx_enable));
      fb_diag_irq <= diag_event & irq_en_r;
      in_bytes  <= field_size(size_sel_r);
      out_bytes <= ro_mode_r ? `IN_RO_OUT : field_size(size_sel_r);
      // shortest run between line edges tracks the master bit time
      fb_prev_r <= fb_lvl_r;
      if (fb_lvl_r != fb_prev_r) begin
        run_r <= 16'h0000;
        if (run_r < rate_min_r)
          rate_min_r <= run_r;
      end else if (run_r != 16'hFFFF)
        run_r <= run_r + 16'h0001;
      // hold window in 10 ms steps; prescaler restarts at each load
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      if (tick_cnt_r == TICK_STEP - 1) begin
        tick_cnt_r <= 32'h0000_0000;
        if (hold_left_r != 8'h00)
          hold_left_r <= hold_left_r - 8'h01;
      end
      if (new_code_valid) begin
        pend_r      <= 1'b1;
        pend_code_r <= new_code;
      end
      if (pend_r && hold_left_r == 8'h00 && !new_code_valid) begin
        in_code     <= pend_code_r;
        pend_r      <= 1'b0;
        hold_left_r <= hold_r;
        tick_cnt_r  <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg        aw_full_r, w_full_r;
  reg [7:0]  aw_addr_r;
  reg [31:0] w_data_r;
  reg [3:0]  w_strb_r;

  assign s_axi_awready = ~aw_full_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_full_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r    <= 1'b0;
      w_full_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
      irq_en_r     <= 1'b0;
      ro_mode_r    <= 1'b0;
      size_sel_r   <= 3'd0;
      hold_r       <= 8'h00;
      station_addr <= `ADDR_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (aw_full_r && w_full_r && !s_axi_bvalid) begin
        aw_full_r    <= 1'b0;
        w_full_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (aw_addr_r)
          `OFS_CTRL: if (w_strb_r[0]) begin
            irq_en_r   <= w_data_r[0];
            ro_mode_r  <= w_data_r[1];
            size_sel_r <= w_data_r[4:2];
          end
          `OFS_HOLD: if (w_strb_r[0])
            hold_r <= w_data_r[7:0];
          `OFS_ADDR: if (w_strb_r[0] && w_data_r[6:0] <= `ADDR_MAX && !w_data_r[7])
            station_addr <= w_data_r[6:0];
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RESP_OKAY;
    end else begin
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFS_CTRL:   s_axi_rdata <= {27'h0, size_sel_r, ro_mode_r, irq_en_r};
          `OFS_HOLD:   s_axi_rdata <= {24'h0, hold_r};
          `OFS_ADDR:   s_axi_rdata <= {25'h0, station_addr};
          `OFS_STATUS: s_axi_rdata <= {16'h0, tag_r, 4'h0, pend_r, tx_busy_r,
                                       head_present, dx_enable};
          `OFS_CODE:   s_axi_rdata <= in_code;
          `OFS_RATE:   s_axi_rdata <= {16'h0, rate_min_r};
          `OFS_SIZE:   s_axi_rdata <= {17'h0, out_bytes, 1'b0, in_bytes};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule // rfid_cmd_port
